/* hdl/shp_pkg.sv */
// Shared constants and types for the serial pause and lane three block
package shp_pkg;

    // Lane layout of the four-wire data group
    localparam int LANE_COUNT = 4;
    localparam int LANE_DATA_IN = 0; // Serial input, lane 0
    localparam int LANE_DATA_OUT = 1; // Serial output, lane 1
    localparam int LANE_PAUSE = 3; // Pause pin doubling as lane 3

    // Bit position counter within one byte
    localparam int BIT_POS_W = 3;
    localparam logic [BIT_POS_W-1:0] BIT_POS_RESET = 3'h0;
    localparam logic [BIT_POS_W-1:0] BIT_STEP_SINGLE = 3'h1;
    localparam logic [BIT_POS_W-1:0] BIT_STEP_QUAD = 3'h4;

    // Reset values of the synchronised pins
    localparam logic CS_N_RESET = 1'b1;
    localparam logic SCK_RESET = 1'b0;
    localparam logic [LANE_COUNT-1:0] LANES_RESET = 4'h8; // Pause lane idles high
    localparam logic [LANE_COUNT-1:0] LANES_OFF = 4'h0;
    localparam logic [LANE_COUNT-1:0] LANES_ALL = 4'hF;

    // Pause state machine
    typedef enum logic [0:0] {
        SHP_RUN = 1'b0,
        SHP_PAUSED = 1'b1
    } shp_pause_state_type;

endpackage : shp_pkg

/* hdl/shp_sync2.sv */
// Two flip-flop synchroniser with a constant reset value
`timescale 1ns/1ps
module shp_sync2 #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic clock_i,
    input wire logic reset_n_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] meta_r;

    // First stage feeds only the second stage
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            meta_r <= RESET_VAL;
            sync_o <= RESET_VAL;
        end else begin
            meta_r <= async_i;
            sync_o <= meta_r;
        end
    end

endmodule : shp_sync2

/* hdl/shp_pause_lane.sv */
// Device-side pause function and shared quad lane three of a serial flash port
`timescale 1ns/1ps
module shp_pause_lane
    import shp_pkg::*;
(
    input wire logic clock_i,
    input wire logic reset_n_i,
    // Pins to and from the host
    input wire logic cs_n_i,
    input wire logic sck_i,
    input wire logic [LANE_COUNT-1:0] lanes_i,
    output logic [LANE_COUNT-1:0] lanes_o,
    output logic [LANE_COUNT-1:0] lanes_oe_o,
    // Command core, same clock
    input wire logic quad_in_i,
    input wire logic quad_out_i,
    input wire logic single_out_i,
    input wire logic [LANE_COUNT-1:0] tx_data_i,
    output logic tx_take_o,
    output logic rx_valid_o,
    output logic [LANE_COUNT-1:0] rx_data_o,
    output logic [BIT_POS_W-1:0] bit_pos_o,
    output logic op_start_o,
    output logic op_end_o,
    output logic paused_o,
    input wire logic op_busy_i,
    output logic op_busy_o
);

    logic rst_meta_r;
    logic rst_n_r;
    logic cs_n_s;
    logic sck_s;
    logic [LANE_COUNT-1:0] lanes_s;
    logic sck_d_r;
    logic cs_n_d_r;
    logic sck_rise;
    logic sck_fall;
    logic cs_fall;
    logic cs_rise;
    logic selected;
    logic quad_lane_en;
    logic pause_req;
    logic hold_ok;
    logic rise_ok;
    logic fall_ok;
    shp_pause_state_type state_r;
    shp_pause_state_type state_nxt;
    logic [BIT_POS_W-1:0] bit_cnt_r;
    logic [LANE_COUNT-1:0] out_r;
    logic [LANE_COUNT-1:0] oe_r;

    // Reset release through two flip-flops
    always_ff @(posedge clock_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_meta_r <= 1'b0;
            rst_n_r <= 1'b0;
        end else begin
            rst_meta_r <= 1'b1;
            rst_n_r <= rst_meta_r;
        end
    end

    // Pin synchronisers
    shp_sync2 #(.WIDTH(1), .RESET_VAL(CS_N_RESET)) u_sync_cs (
        .clock_i(clock_i),
        .reset_n_i(rst_n_r),
        .async_i(cs_n_i),
        .sync_o(cs_n_s)
    );

    shp_sync2 #(.WIDTH(1), .RESET_VAL(SCK_RESET)) u_sync_sck (
        .clock_i(clock_i),
        .reset_n_i(rst_n_r),
        .async_i(sck_i),
        .sync_o(sck_s)
    );

    // Lane three resets high, as the pull-up would hold it
    shp_sync2 #(.WIDTH(LANE_COUNT), .RESET_VAL(LANES_RESET)) u_sync_lanes (
        .clock_i(clock_i),
        .reset_n_i(rst_n_r),
        .async_i(lanes_i),
        .sync_o(lanes_s)
    );

    // Previous samples for edge detection
    always_ff @(posedge clock_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            sck_d_r <= SCK_RESET;
            cs_n_d_r <= CS_N_RESET;
        end else begin
            sck_d_r <= sck_s;
            cs_n_d_r <= cs_n_s;
        end
    end

    // Edge and condition decode
    assign sck_rise = sck_s && !sck_d_r;
    assign sck_fall = !sck_s && sck_d_r;
    assign cs_fall = !cs_n_s && cs_n_d_r;
    assign cs_rise = cs_n_s && !cs_n_d_r;
    assign selected = !cs_n_s;
    assign quad_lane_en = quad_in_i || quad_out_i;
    assign pause_req = !lanes_s[LANE_PAUSE] && !quad_lane_en;
    assign hold_ok = selected && !sck_s;
    assign rise_ok = sck_rise && selected && (state_r == SHP_RUN);
    assign fall_ok = sck_fall && selected && (state_r == SHP_RUN);

    // Pause state: enters only when selected with clock low
    always_comb begin
        state_nxt = state_r;
        unique case (state_r)
            SHP_RUN: begin
                if (pause_req && hold_ok) begin
                    state_nxt = SHP_PAUSED;
                end
            end
            SHP_PAUSED: begin
                if (!pause_req || !selected) begin
                    state_nxt = SHP_RUN;
                end
            end
        endcase
    end

    always_ff @(posedge clock_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            state_r <= SHP_RUN;
        end else begin
            state_r <= state_nxt;
        end
    end

    // Bit position; held untouched while paused
    always_ff @(posedge clock_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            bit_cnt_r <= BIT_POS_RESET;
        end else if (cs_fall) begin
            bit_cnt_r <= BIT_POS_RESET;
        end else if (rise_ok || (fall_ok && !single_out_i && quad_out_i)) begin
            bit_cnt_r <= bit_cnt_r + (quad_lane_en ? BIT_STEP_QUAD : BIT_STEP_SINGLE);
        end else if (fall_ok && single_out_i) begin
            bit_cnt_r <= bit_cnt_r + BIT_STEP_SINGLE;
        end
    end

    // Input capture on rising edges
    always_ff @(posedge clock_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            rx_valid_o <= 1'b0;
            rx_data_o <= LANES_OFF;
        end else begin
            rx_valid_o <= rise_ok;
            if (rise_ok) begin
                if (quad_in_i) begin
                    rx_data_o <= lanes_s;
                end else begin
                    rx_data_o <= {3'h0, lanes_s[LANE_DATA_IN]};
                end
            end
        end
    end

    // Output launch on falling edges, floated while paused or deselected
    always_ff @(posedge clock_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            out_r <= LANES_OFF;
            oe_r <= LANES_OFF;
        end else if (!selected || state_nxt == SHP_PAUSED) begin
            oe_r <= LANES_OFF;
        end else if (fall_ok) begin
            if (quad_out_i) begin
                out_r <= tx_data_i;
                oe_r <= LANES_ALL;
            end else if (single_out_i) begin
                out_r <= {2'h0, tx_data_i[0], 1'b0};
                oe_r <= 4'h2;
            end else begin
                oe_r <= LANES_OFF;
            end
        end
    end

    // Self-timed busy registered for one cycle, unaffected by pause
    always_ff @(posedge clock_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            op_busy_o <= 1'b0;
        end else begin
            op_busy_o <= op_busy_i;
        end
    end

    // Operation framing pulses
    always_ff @(posedge clock_i or negedge rst_n_r) begin
        if (!rst_n_r) begin
            op_start_o <= 1'b0;
            op_end_o <= 1'b0;
        end else begin
            op_start_o <= cs_fall;
            op_end_o <= cs_rise;
        end
    end

    assign tx_take_o = fall_ok && (quad_out_i || single_out_i);
    assign lanes_o = out_r;
    assign lanes_oe_o = oe_r;
    assign bit_pos_o = bit_cnt_r;
    assign paused_o = (state_r == SHP_PAUSED);

    // Checks
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_r);

    sequence pause_entry_s;
        (state_r == SHP_RUN) ##1 (state_r == SHP_PAUSED);
    endsequence

    sequence quad_launch_s;
        fall_ok && quad_out_i;
    endsequence

    pause_ignore_a: assert property ((state_r == SHP_PAUSED) |=> !rx_valid_o)
        else $error("Input captured while paused");

    pause_float_a: assert property ((state_r == SHP_PAUSED) |=> oe_r == LANES_OFF)
        else $error("Output driven while paused");

    pause_keep_a: assert property (((state_r == SHP_PAUSED) && !cs_fall) |=> $stable(bit_cnt_r))
        else $error("Bit position changed while paused");

    pause_start_a: assert property (pause_entry_s |-> $past(hold_ok))
        else $error("Pause began without select low and clock low");

    busy_thru_a: assert property (((state_r == SHP_PAUSED) && op_busy_i) |=> op_busy_o)
        else $error("Busy lost during pause");

    quad_capture_a: assert property ((rise_ok && quad_in_i) |=> rx_valid_o && (rx_data_o == $past(lanes_s)))
        else $error("Quad nibble not captured");

    quad_launch_a: assert property (quad_launch_s |=> (oe_r == LANES_ALL) && (out_r == $past(tx_data_i)))
        else $error("Quad nibble not launched");

    pull_release_a: assert property (((state_r == SHP_PAUSED) && lanes_s[LANE_PAUSE]) |=> (state_r == SHP_RUN))
        else $error("Pause held with pin high");

    frame_start_a: assert property (cs_fall |=> op_start_o && (bit_cnt_r == BIT_POS_RESET))
        else $error("Operation start not framed");

    rise_only_a: assert property (rx_valid_o |-> $past(rise_ok))
        else $error("Capture without rising edge");

    resume_pos_a: assert property ((rise_ok && !quad_lane_en && !cs_fall) |=> bit_cnt_r == BIT_POS_W'($past(bit_cnt_r) + BIT_STEP_SINGLE))
        else $error("Bit position not advanced by one");

endmodule : shp_pause_lane

/* bench/shp_host_model.sv */
// SPI host model driving select, clock and lane pins
`timescale 1ns/1ps
module shp_host_model (
    input wire logic clock_i,
    input wire logic [3:0] dev_lanes_i,
    input wire logic [3:0] dev_oe_i,
    output logic cs_n_o,
    output logic sck_o,
    output logic [3:0] pins_o
);
    logic [3:0] drv_en;
    logic [3:0] drv_val;
    logic tgl;
    // Idle levels: deselected, clock low, lanes released
    initial begin
        cs_n_o = 1'h1;
        sck_o = 1'h0;
        drv_en = 4'h0;
        drv_val = 4'h0;
        tgl = 1'h0;
    end
    // Toggle pattern for released lanes
    always @(posedge clock_i) tgl <= ~tgl;
    // Wire levels; undriven pause lane pulled up
    always_comb begin
        for (int k = 0; k < 4; k++) begin
            pins_o[k] = dev_oe_i[k] ? dev_lanes_i[k] : (drv_en[k] ? drv_val[k] : ((k == 3) | tgl));
        end
    end
    // Select edge frames an operation
    task automatic sel(input logic v);
        @(posedge clock_i);
        cs_n_o <= v;
        repeat (5) @(posedge clock_i);
    endtask : sel
    // One clock phase of 60 ns; lanes may also change while high
    task automatic sck(input logic v);
        @(posedge clock_i);
        sck_o <= v;
        repeat (5) @(posedge clock_i);
    endtask : sck
    // Host lane drive; pause may be pulled low with select high or clock high
    task automatic put(input logic [3:0] en, input logic [3:0] val);
        @(posedge clock_i);
        drv_en <= en;
        drv_val <= val;
        repeat (5) @(posedge clock_i);
    endtask : put
endmodule : shp_host_model

/* bench/shp_pause_lane_tb.sv */
// Self-checking bench for the pause and lane three block
`timescale 1ns/1ps
module shp_pause_lane_tb;
    import shp_pkg::*;
    logic clock_i = 1'h0;
    logic reset_n_i;
    logic cs_n;
    logic sck;
    logic quad_in;
    logic quad_out;
    logic single_out;
    logic busy;
    logic [3:0] pins;
    logic [3:0] lanes;
    logic [3:0] oe;
    logic [3:0] rx_data;
    logic [3:0] rx_last;
    logic [3:0] tx_data;
    logic [7:0] rx_byte;
    logic tx_take;
    logic rx_valid;
    logic op_start;
    logic op_end;
    logic paused;
    logic busy_o;
    logic [BIT_POS_W-1:0] bit_pos;
    int error_cnt = 0;
    int tests_run = 0;
    int rx_cnt = 0;
    int tx_cnt = 0;
    int start_cnt = 0;
    int end_cnt = 0;
    // Clock
    always #5 clock_i = ~clock_i;
    shp_host_model shp_host_model_inst (
        .clock_i(clock_i),
        .dev_lanes_i(lanes),
        .dev_oe_i(oe),
        .cs_n_o(cs_n),
        .sck_o(sck),
        .pins_o(pins)
    );
    shp_pause_lane shp_pause_lane_inst (
        .clock_i(clock_i),
        .reset_n_i(reset_n_i),
        .cs_n_i(cs_n),
        .sck_i(sck),
        .lanes_i(pins),
        .lanes_o(lanes),
        .lanes_oe_o(oe),
        .quad_in_i(quad_in),
        .quad_out_i(quad_out),
        .single_out_i(single_out),
        .tx_data_i(tx_data),
        .tx_take_o(tx_take),
        .rx_valid_o(rx_valid),
        .rx_data_o(rx_data),
        .bit_pos_o(bit_pos),
        .op_start_o(op_start),
        .op_end_o(op_end),
        .paused_o(paused),
        .op_busy_i(busy),
        .op_busy_o(busy_o)
    );
    // Pulse counters and received byte assembly
    always @(posedge clock_i) begin
        if (rx_valid === 1'h1) begin
            rx_cnt++;
            rx_last = rx_data;
            rx_byte = {rx_byte[6:0], rx_data[0]};
        end
        if (tx_take === 1'h1) tx_cnt++;
        if (op_start === 1'h1) start_cnt++;
        if (op_end === 1'h1) end_cnt++;
    end
    task automatic chk(input string what, input logic [3:0] exp, input logic [3:0] got);
        tests_run++;
        if (got !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic report_and_stop();
        $display("mismatches %0d checks %0d", error_cnt, tests_run);
        if (error_cnt == 0 && tests_run > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : report_and_stop
    // Idle pause lane floats high, no pause seen
    task automatic t_idle();
        chk("paused", 4'h0, {3'h0, paused});
        chk("oe", 4'h0, oe);
    endtask : t_idle
    // Single byte 0xA5 on lane 0, framed by select
    task automatic t_single();
        logic [7:0] b = 8'hA5;
        shp_host_model_inst.sel(1'h0);
        chk("start", 4'h1, start_cnt[3:0]);
        for (int i = 7; i >= 0; i--) begin
            shp_host_model_inst.put(4'h1, {3'h0, b[i]});
            shp_host_model_inst.sck(1'h1);
            shp_host_model_inst.sck(1'h0);
        end
        chk("rx count", 4'h8, rx_cnt[3:0]);
        chk("rx bit", 4'h1, rx_last);
        chk("rx byte hi", 4'hA, rx_byte[7:4]);
        chk("rx byte lo", 4'h5, rx_byte[3:0]);
        chk("bit pos", 4'h0, {1'h0, bit_pos});
        shp_host_model_inst.sel(1'h1);
        chk("end", 4'h1, end_cnt[3:0]);
    endtask : t_single
    // Pause mid-byte during single output
    task automatic t_pause();
        shp_host_model_inst.sel(1'h0);
        single_out <= 1'h1;
        tx_data <= 4'h1;
        shp_host_model_inst.sck(1'h1);
        shp_host_model_inst.sck(1'h0);
        chk("oe run", 4'h2, oe);
        chk("lane1 out", 4'h2, lanes);
        chk("take", 4'h1, tx_cnt[3:0]);
        shp_host_model_inst.put(4'h9, 4'h0);
        chk("paused", 4'h1, {3'h0, paused});
        chk("oe held", 4'h0, oe);
        busy <= 1'h1;
        shp_host_model_inst.sck(1'h1);
        chk("busy", 4'h1, {3'h0, busy_o});
        shp_host_model_inst.sck(1'h0);
        chk("rx none", 4'h9, rx_cnt[3:0]);
        chk("pos kept", 4'h2, {1'h0, bit_pos});
        shp_host_model_inst.put(4'h1, 4'h0);
        chk("resumed", 4'h0, {3'h0, paused});
        chk("start once", 4'h2, start_cnt[3:0]);
        shp_host_model_inst.sck(1'h1);
        chk("pos next", 4'h3, {1'h0, bit_pos});
        busy <= 1'h0;
        single_out <= 1'h0;
        shp_host_model_inst.sck(1'h0);
        chk("busy off", 4'h0, {3'h0, busy_o});
        shp_host_model_inst.sel(1'h1);
    endtask : t_pause
    // Pause refused with clock high or select high
    task automatic t_defer();
        shp_host_model_inst.put(4'h9, 4'h0);
        chk("no sel", 4'h0, {3'h0, paused});
        shp_host_model_inst.put(4'h1, 4'h0);
        shp_host_model_inst.sel(1'h0);
        shp_host_model_inst.sck(1'h1);
        shp_host_model_inst.put(4'h9, 4'h0);
        chk("sck high", 4'h0, {3'h0, paused});
        shp_host_model_inst.sck(1'h0);
        chk("deferred", 4'h1, {3'h0, paused});
        shp_host_model_inst.put(4'h1, 4'h0);
        shp_host_model_inst.sel(1'h1);
    endtask : t_defer
    // Quad input then quad output through lane three
    task automatic t_quad();
        quad_in <= 1'h1;
        shp_host_model_inst.sel(1'h0);
        shp_host_model_inst.put(4'hF, 4'h6);
        shp_host_model_inst.sck(1'h1);
        chk("no pause", 4'h0, {3'h0, paused});
        chk("nibble in", 4'h6, rx_last);
        chk("pos quad", 4'h4, {1'h0, bit_pos});
        shp_host_model_inst.sck(1'h0);
        quad_in <= 1'h0;
        quad_out <= 1'h1;
        tx_data <= 4'hC;
        shp_host_model_inst.put(4'h0, 4'h0);
        shp_host_model_inst.sck(1'h1);
        shp_host_model_inst.sck(1'h0);
        chk("oe quad", 4'hF, oe);
        chk("nibble out", 4'hC, pins);
        chk("take quad", 4'h2, tx_cnt[3:0]);
        shp_host_model_inst.sel(1'h1);
        chk("oe off", 4'h0, oe);
        quad_out <= 1'h0;
    endtask : t_quad
    // Watchdog
    initial begin
        #300000;
        error_cnt++;
        report_and_stop();
    end
    initial begin
        reset_n_i <= 1'h0;
        quad_in <= 1'h0;
        quad_out <= 1'h0;
        single_out <= 1'h0;
        busy <= 1'h0;
        tx_data <= 4'h0;
        repeat (2) @(posedge clock_i);
        reset_n_i <= 1'h1;
        repeat (8) @(posedge clock_i);
        t_idle();
        t_single();
        t_pause();
        t_defer();
        t_quad();
        report_and_stop();
    end
endmodule : shp_pause_lane_tb
